// >>> pawc_pkg.sv
/*
  constants, field positions and carrier types shared by the
  configuration-space address window block.
  assumes one clock domain and dword-aligned configuration offsets.
*/
package pawc_pkg;

  // ***********************************************************
  // register offsets in configuration space
  // ***********************************************************
  localparam logic [7:0]  OFF_WIN0       = 8'h10;  // first address window
  localparam logic [7:0]  OFF_WIN_STRIDE = 8'h04;
  localparam logic [7:0]  OFF_WIN5       = 8'h24;  // sixth window, not built
  localparam logic [7:0]  OFF_ROM        = 8'h30;  // expansion rom window
  localparam int          NUM_WIN        = 5;      // windows zero to four

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [31:0] WIN0_RESET     = 32'hFFFFFFC1;  // 64-byte i/o window
  localparam logic [31:0] WINX_RESET     = 32'h00000008;  // prefetch bit only
  localparam logic [31:0] ROM_RESET      = 32'h00000000;

  // ***********************************************************
  // field positions and fixed masks
  // ***********************************************************
  localparam int          BIT_SPACE      = 0;   // 1 = i/o, 0 = memory
  localparam int          BIT_TYPE_LO    = 1;   // below first megabyte
  localparam int          BIT_TYPE_HI    = 2;   // 64-bit, unsupported
  localparam int          BIT_PREF       = 3;
  localparam int          BIT_ROM_EN     = 0;
  localparam int          BIT_WIDTH_HI   = 31;  // add-on width code
  localparam int          BIT_WIDTH_LO   = 30;
  localparam logic [31:0] IO_PLACE       = 32'hFFFFFFFC;  // bits 31:2
  localparam logic [31:0] IO_FORCED      = 32'hFFFFFF00;  // 256 bytes largest
  localparam logic [31:0] MEM_PLACE      = 32'hFFFFFFF0;  // bits 31:4
  localparam logic [31:0] MEM_FORCED     = 32'hE0000000;  // 512 MB largest
  localparam logic [31:0] MEM_ATTR       = 32'h0000000A;  // bits 3 and 1
  localparam logic [31:0] ROM_PLACE      = 32'hFFFFF800;  // bits 31:11
  localparam logic [31:0] ROM_FORCED     = 32'hFFFF0000;  // 64 KB largest
  localparam logic [31:0] LOW_MB_MASK    = 32'hFFF00000;

  // ***********************************************************
  // boot load selectors and rom assembly
  // ***********************************************************
  localparam logic [2:0]  BOOT_SEL_ROM   = 3'h6;  // rom window image
  localparam logic [1:0]  ROM_LAST_BYTE  = 2'h3;  // four byte reads a word

  // ***********************************************************
  // carrier types
  // ***********************************************************
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pawc_cfg_t;

  typedef struct packed {
    logic        mem;
    logic        io;
    logic        rd;
    logic [31:0] addr;
  } pawc_bus_t;

  typedef struct packed {
    logic        wr;
    logic [2:0]  sel;
    logic [31:0] data;
  } pawc_boot_t;

  typedef enum logic [1:0] {
    ROM_IDLE  = 2'b00,
    ROM_ISSUE = 2'b01,
    ROM_WAIT  = 2'b10,
    ROM_DONE  = 2'b11
  } pawc_rom_state_t;

endpackage : pawc_pkg

// >>> pawc_window_cfg.sv
/*
  address window and expansion rom window registers of a pci target:
  sizing read-back, boot-loaded enables, decode and rom word assembly.
  assumes the configuration cycle decoder, the boot memory loader, the
  command register and an 8-bit external rom all sit outside this block,
  all synchronous to clk_i.
*/
// Notes on behaviour
// - i/o window reads one in bit 0
// - i/o placement bits 31:2, unusable bits zero
// - windows above zero: placement enabled by boot
// - i/o bit 1 zero; disabled window reads zero
// - memory sizing 16 bytes to 512 megabytes
// - add-on width is mask bits 31:30: 11 once placed, else 00
// - memory bits 3..1 show region attributes
// - sixth window reads zero, never decodes
// - i/o sizing 4 to 256 bytes
// - window zero powers up 64-byte i/o
// - boot may turn window zero into memory
// - rom window at 30h, reset zero, boot-loaded
// - rom bits 31:11 and 0 writable, rest zero
// - rom access assembled from byte reads
// - rom placement boot-enabled, at most 64K
// - rom bit 0 plus memory enable decode
// - memory type 00 anywhere, 01 below 1MB
// - prefetch zero on window zero, else boot
`timescale 1ns/1ps

module pawc_window_cfg (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // configuration access
  input  wire pawc_pkg::pawc_cfg_t  cfg_i,
  output logic                      cfg_ack_o,
  output logic [31:0]               cfg_rdata_o,
  // boot memory image load
  input  wire pawc_pkg::pawc_boot_t boot_i,
  // command register enables
  input  wire logic                 mem_space_en_i,
  input  wire logic                 io_space_en_i,
  // pci address decode
  input  wire pawc_pkg::pawc_bus_t  bus_i,
  output logic [4:0]                win_hit_o,
  output logic                      rom_hit_o,
  output logic [7:0]                win_width_o,
  // external rom byte port
  output logic                      ext_rd_o,
  output logic [15:0]               ext_addr_o,
  input  wire logic [7:0]           ext_data_i,
  input  wire logic                 ext_ack_i,
  // assembled rom word
  output logic                      rom_valid_o,
  output logic [31:0]               rom_data_o
);

  // ***********************************************************
  // helper functions
  // ***********************************************************

  // clean a boot image into a window mask of writable bits
  function automatic logic [31:0] win_mask(input logic [2:0] idx,
                                           input logic [31:0] v);
    logic [31:0] m;
    m = v;
    if (idx == 3'h0)
      m[pawc_pkg::BIT_PREF] = 1'b0;
    if (m[pawc_pkg::BIT_SPACE])
    begin
      m[pawc_pkg::BIT_TYPE_LO] = 1'b0;
      if ((m & pawc_pkg::IO_PLACE) != 32'h00000000)
        m = m | pawc_pkg::IO_FORCED;
    end
    else
    begin
      m[pawc_pkg::BIT_TYPE_HI] = 1'b0;
      if ((m & pawc_pkg::MEM_PLACE) != 32'h00000000)
        m = m | pawc_pkg::MEM_FORCED;
    end
    return m;
  endfunction : win_mask

  // sizing read-back of one address window
  function automatic logic [31:0] win_read(input logic [31:0] m,
                                           input logic [31:0] b);
    logic [31:0] r;
    r = 32'h00000000;
    if (m[pawc_pkg::BIT_SPACE] && ((m & pawc_pkg::IO_PLACE) != 32'h00000000))
      r = (b & m & pawc_pkg::IO_PLACE) | 32'h00000001;
    else if (!m[pawc_pkg::BIT_SPACE] && ((m & pawc_pkg::MEM_PLACE) != 32'h00000000))
      r = (b & m & pawc_pkg::MEM_PLACE) | (m & pawc_pkg::MEM_ATTR);
    return r;
  endfunction : win_read

  // byte-lane write through a mask of writable bits
  function automatic logic [31:0] lane_write(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be,
                                             input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = (old[i*8 +: 8] & ~m[i*8 +: 8]) | (wd[i*8 +: 8] & m[i*8 +: 8]);
    return r;
  endfunction : lane_write

  // ***********************************************************
  // state
  // ***********************************************************
  logic [31:0]               mask_q [pawc_pkg::NUM_WIN];
  logic [31:0]               base_q [pawc_pkg::NUM_WIN];
  logic [31:0]               rom_mask_q;
  logic [31:0]               rom_base_q;
  pawc_pkg::pawc_rom_state_t rom_state_q;
  logic [1:0]                rom_byte_q;
  logic [31:0]               rom_word_q;

  // ***********************************************************
  // address decode of configuration offsets
  // ***********************************************************
  logic                      cfg_win_sel;
  logic [2:0]                cfg_win_idx;
  logic                      cfg_rom_sel;
  logic [7:0]                cfg_rel;

  // window index from offset; the sixth window is left unselected
  always_comb
  begin
    cfg_rel     = cfg_i.addr - pawc_pkg::OFF_WIN0;
    cfg_win_idx = cfg_rel[4:2];
    cfg_win_sel = 1'b0;
    cfg_rom_sel = 1'b0;
    if ((cfg_i.addr >= pawc_pkg::OFF_WIN0) && (cfg_i.addr < pawc_pkg::OFF_WIN5))
      cfg_win_sel = 1'b1;
    else if (cfg_i.addr == pawc_pkg::OFF_ROM)
      cfg_rom_sel = 1'b1;
  end

  // ***********************************************************
  // address window registers
  // ***********************************************************

  // writable-bit masks: reset image, then boot image if present
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mask_q[0] <= pawc_pkg::WIN0_RESET;
      for (int w = 1; w < pawc_pkg::NUM_WIN; w++)
        mask_q[w] <= pawc_pkg::WINX_RESET;
    end
    else if (boot_i.wr && (boot_i.sel < 3'(pawc_pkg::NUM_WIN)))
      mask_q[boot_i.sel] <= win_mask(boot_i.sel, boot_i.data);
  end

  // base placement written by configuration software
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int w = 0; w < pawc_pkg::NUM_WIN; w++)
        base_q[w] <= 32'h00000000;
    end
    else if (cfg_i.wr && cfg_win_sel)
      base_q[cfg_win_idx] <= lane_write(base_q[cfg_win_idx], cfg_i.wdata, cfg_i.be,
                                        mask_q[cfg_win_idx]);
  end

  // ***********************************************************
  // expansion rom window register
  // ***********************************************************

  // rom mask: bits 31:11 from boot, widened so size stays at most 64K
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rom_mask_q <= pawc_pkg::ROM_RESET;
    end
    else if (boot_i.wr && (boot_i.sel == pawc_pkg::BOOT_SEL_ROM))
    begin
      if ((boot_i.data & pawc_pkg::ROM_PLACE) != 32'h00000000)
        rom_mask_q <= (boot_i.data & pawc_pkg::ROM_PLACE) | pawc_pkg::ROM_FORCED
                      | 32'h00000001;
      else
        rom_mask_q <= 32'h00000000;                  // absent rom stays dead
    end
  end

  // rom base and decode enable; bits 10:1 never stored
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rom_base_q <= pawc_pkg::ROM_RESET;
    else if (cfg_i.wr && cfg_rom_sel)
      rom_base_q <= lane_write(rom_base_q, cfg_i.wdata, cfg_i.be, rom_mask_q);
  end

  // ***********************************************************
  // configuration read-back
  // ***********************************************************

  // one-cycle answer; unlisted offsets and the sixth window read zero
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h00000000;
    end
    else
    begin
      cfg_ack_o   <= cfg_i.rd | cfg_i.wr;
      cfg_rdata_o <= 32'h00000000;
      if (cfg_i.rd && cfg_win_sel)
      begin
        cfg_rdata_o <= win_read(mask_q[cfg_win_idx], base_q[cfg_win_idx]);
      end
      else if (cfg_i.rd && cfg_rom_sel)
      begin
        cfg_rdata_o <= rom_base_q & rom_mask_q;
      end
    end
  end

  // ***********************************************************
  // pci address decode
  // ***********************************************************
  logic [4:0]                hit_d;
  logic                      rom_hit_d;

  // compare only placement bits; the low-megabyte type adds a range check
  always_comb
  begin
    for (int w = 0; w < pawc_pkg::NUM_WIN; w++)
    begin
      hit_d[w] = 1'b0;
      if (mask_q[w][pawc_pkg::BIT_SPACE])
      begin
        hit_d[w] = io_space_en_i && bus_i.io
                   && ((mask_q[w] & pawc_pkg::IO_PLACE) != 32'h00000000)
                   && (((bus_i.addr ^ base_q[w]) & mask_q[w] & pawc_pkg::IO_PLACE)
                       == 32'h00000000);
      end
      else
      begin
        hit_d[w] = mem_space_en_i && bus_i.mem
                   && ((mask_q[w] & pawc_pkg::MEM_PLACE) != 32'h00000000)
                   && (((bus_i.addr ^ base_q[w]) & mask_q[w] & pawc_pkg::MEM_PLACE)
                       == 32'h00000000)
                   && (!mask_q[w][pawc_pkg::BIT_TYPE_LO]
                       || ((bus_i.addr & pawc_pkg::LOW_MB_MASK) == 32'h00000000));
      end
    end
    rom_hit_d = mem_space_en_i && bus_i.mem && rom_base_q[pawc_pkg::BIT_ROM_EN]
                && rom_mask_q[pawc_pkg::BIT_ROM_EN]
                && (((bus_i.addr ^ rom_base_q) & rom_mask_q & pawc_pkg::ROM_PLACE)
                    == 32'h00000000);
  end

  // registered hit flags; no sixth window hit exists at all
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      win_hit_o <= 5'h00;
      rom_hit_o <= 1'b0;
    end
    else
    begin
      win_hit_o <= hit_d;
      rom_hit_o <= rom_hit_d;
    end
  end

  // add-on width code of windows one to four, from the boot image
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      win_width_o <= 8'h00;
    end
    else
    begin
      for (int w = 1; w < pawc_pkg::NUM_WIN; w++)
      begin
        win_width_o[(w-1)*2 +: 2] <= mask_q[w][pawc_pkg::BIT_WIDTH_HI:pawc_pkg::BIT_WIDTH_LO];
      end
    end
  end

  // ***********************************************************
  // rom word assembly
  // ***********************************************************

  // four byte reads, lowest byte first; rom reads that hit while a fetch is busy are ignored
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rom_state_q <= pawc_pkg::ROM_IDLE;
      rom_byte_q  <= 2'h0;
      rom_word_q  <= 32'h00000000;
      ext_rd_o    <= 1'b0;
      ext_addr_o  <= 16'h0000;
      rom_valid_o <= 1'b0;
      rom_data_o  <= 32'h00000000;
    end
    else
    begin
      rom_valid_o <= 1'b0;
      case (rom_state_q)
        pawc_pkg::ROM_IDLE:
        begin
          if (rom_hit_d && bus_i.rd)
          begin
            rom_byte_q  <= 2'h0;
            ext_addr_o  <= {bus_i.addr[15:2], 2'h0};
            rom_state_q <= pawc_pkg::ROM_ISSUE;
          end
        end
        pawc_pkg::ROM_ISSUE:
        begin
          ext_rd_o    <= 1'b1;
          rom_state_q <= pawc_pkg::ROM_WAIT;
        end
        pawc_pkg::ROM_WAIT:
        begin
          if (ext_ack_i)
          begin
            ext_rd_o                     <= 1'b0;
            rom_word_q[rom_byte_q*8 +: 8] <= ext_data_i;
            if (rom_byte_q == pawc_pkg::ROM_LAST_BYTE)
            begin
              rom_state_q <= pawc_pkg::ROM_DONE;
            end
            else
            begin
              rom_byte_q  <= rom_byte_q + 2'h1;
              ext_addr_o  <= ext_addr_o + 16'h0001;
              rom_state_q <= pawc_pkg::ROM_ISSUE;
            end
          end
        end
        pawc_pkg::ROM_DONE:
        begin
          rom_valid_o <= 1'b1;
          rom_data_o  <= rom_word_q;
          rom_state_q <= pawc_pkg::ROM_IDLE;
        end
        default:
        begin
          rom_state_q <= pawc_pkg::ROM_IDLE;
        end
      endcase
    end
  end

endmodule : pawc_window_cfg

// >>> pawc_window_cfg_chk.sv
/*
  checker for the address window block: config answers, fixed zero
  bits, rom decode and rom byte fetch. assumes one clock, bound in.
*/
`timescale 1ns/1ps
module pawc_window_cfg_chk (
  // clock and reset
  input wire logic                clk_i,
  input wire logic                resetn_i,
  // config side
  input wire pawc_pkg::pawc_cfg_t cfg_i,
  input wire logic                cfg_ack_o,
  input wire logic [31:0]         cfg_rdata_o,
  // decode and rom side
  input wire logic                mem_space_en_i,
  input wire pawc_pkg::pawc_bus_t bus_i,
  input wire logic                rom_hit_o,
  input wire logic                ext_rd_o,
  input wire logic [15:0]         ext_addr_o,
  input wire logic                ext_ack_i,
  input wire logic                rom_valid_o
);
  // ***********************************************************
  // properties
  // ***********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_ack_follows_req: assert property ((cfg_i.rd || cfg_i.wr) |=> cfg_ack_o)
    else $error("config request not answered");
  a_rdata_idle_zero: assert property (!cfg_i.rd |=> cfg_rdata_o == 32'h00000000)
    else $error("read data not zero outside a read");
  a_sixth_reads_zero: assert property
    (cfg_i.rd && cfg_i.addr == pawc_pkg::OFF_WIN5 |=> cfg_rdata_o == 32'h00000000)
    else $error("sixth window not zero");
  a_win_low_bits: assert property
    (cfg_i.rd && cfg_i.addr inside {[8'h10:8'h20]}
      |=> (cfg_rdata_o[0] ? !cfg_rdata_o[1] : !cfg_rdata_o[2]))
    else $error("window low bits wrong");
  a_win0_no_prefetch: assert property
    (cfg_i.rd && cfg_i.addr == pawc_pkg::OFF_WIN0 |=> !cfg_rdata_o[3])
    else $error("window zero prefetch set");
  a_rom_reserved_zero: assert property
    (cfg_i.rd && cfg_i.addr == pawc_pkg::OFF_ROM |=> cfg_rdata_o[10:1] == 10'h000)
    else $error("rom reserved bits set");
  a_rom_needs_enable: assert property
    (!(mem_space_en_i && bus_i.mem) |=> !rom_hit_o)
    else $error("rom hit without memory enable");
  a_ext_rd_holds: assert property
    (ext_rd_o && !ext_ack_i |=> ext_rd_o && $stable(ext_addr_o))
    else $error("rom byte request dropped early");
  a_rom_word_bound: assert property
    ($rose(ext_rd_o) |-> ##[1:60] rom_valid_o)
    else $error("rom word not assembled in time");
  a_valid_single: assert property (rom_valid_o |=> !rom_valid_o)
    else $error("rom valid longer than one cycle");

  // main scenarios reached
  c_rom_word: cover property (rom_valid_o);
  c_rom_hit: cover property (rom_hit_o);
  c_sixth_read: cover property (cfg_i.rd && cfg_i.addr == pawc_pkg::OFF_WIN5);
endmodule : pawc_window_cfg_chk

// >>> pawc_rom_model.sv
/*
  external 8-bit rom seen from the block's byte port.
  assumes requests held until acknowledged, same clock as the block.
*/
`timescale 1ns/1ps
module pawc_rom_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // pacing from the bench
  input  wire logic        slow_i,
  // byte port
  input  wire logic        ext_rd_i,
  input  wire logic [15:0] ext_addr_i,
  output logic [7:0]       ext_data_o,
  output logic             ext_ack_o
);
  logic [1:0] wait_q;

  // answer at once or after four cycles; bus toggles when idle
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wait_q     <= 2'h0;
      ext_ack_o  <= 1'b0;
      ext_data_o <= 8'h00;
    end
    else if (ext_rd_i && !ext_ack_o && (wait_q == 2'h3 || !slow_i))
    begin
      ext_ack_o  <= 1'b1;
      ext_data_o <= ext_addr_i[7:0] ^ 8'h5A;  // byte from its address
      wait_q     <= 2'h0;
    end
    else
    begin
      ext_ack_o  <= 1'b0;
      ext_data_o <= ~ext_data_o;  // no stale byte to lean on
      wait_q     <= ext_rd_i ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule : pawc_rom_model

// >>> test_pawc_window_cfg.sv
/*
  self-checking bench for the address window block.
  assumes the checker and rom model files are compiled first.
*/
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("unexpected %s: expected %h seen %h", what, exp, got); \
    end \
  end

module test_pawc_window_cfg;
  logic                 clk_i, resetn_i, mem_en, io_en, slow;
  pawc_pkg::pawc_cfg_t  cfg;
  pawc_pkg::pawc_boot_t boot;
  pawc_pkg::pawc_bus_t  bus;
  logic                 cfg_ack, rom_hit, ext_rd, ext_ack, rom_valid;
  logic [31:0]          cfg_rdata, rom_data;
  logic [4:0]           win_hit;
  logic [7:0]           win_width, ext_data;
  logic [15:0]          ext_addr;
  int                   fails, samples_checked;
  // sizing table: boot selector, boot image, read-back after all ones
  logic [2:0]  t_sel [11] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h0, 3'h6, 3'h6, 3'h2, 3'h6};
  logic [31:0] t_img [11] = '{32'hFFFFFFFD, 32'hFFFFFFF1, 32'hFFFFFF01, 32'hFFFFFFC4,
    32'hFFFFFFC8, 32'h0000000A, 32'hFFFFFFCA, 32'h00000001, 32'hFFFF0000,
    32'hE0000000, 32'hFFFFFFFF};
  logic [31:0] t_exp [11] = '{32'hFFFFFFFD, 32'hFFFFFFF1, 32'hFFFFFF01, 32'hFFFFFFC0,
    32'hFFFFFFC8, 32'h00000000, 32'hFFFFFFC2, 32'h00000000, 32'hFFFF0001,
    32'hE0000000, 32'hFFFFF801};

  pawc_window_cfg DUT (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_i(cfg),
    .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata), .boot_i(boot),
    .mem_space_en_i(mem_en), .io_space_en_i(io_en), .bus_i(bus),
    .win_hit_o(win_hit), .rom_hit_o(rom_hit), .win_width_o(win_width),
    .ext_rd_o(ext_rd), .ext_addr_o(ext_addr), .ext_data_i(ext_data),
    .ext_ack_i(ext_ack), .rom_valid_o(rom_valid), .rom_data_o(rom_data));

  pawc_rom_model u_rom (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow),
    .ext_rd_i(ext_rd), .ext_addr_i(ext_addr), .ext_data_o(ext_data),
    .ext_ack_o(ext_ack));

  // ***********************************************************
  // access tasks: each waits an edge, so no signal is set twice
  // ***********************************************************
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic stop_test;
    $display("compares %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    step();
    cfg = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
    step();
    cfg = '0;
  endtask : cfg_wr

  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    step();
    cfg = '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: 32'h00000000};
    step();
    cfg = '0;
    `CHK("config ack", 1'b1, cfg_ack)
    `CHK("config read", exp, cfg_rdata)
  endtask : cfg_rd

  task automatic boot_ld(input logic [2:0] s, input logic [31:0] d);
    step();
    boot = '{wr: 1'b1, sel: s, data: d};
    step();
    boot = '0;
  endtask : boot_ld

  task automatic dec(input logic io, input logic mem, input logic [31:0] a,
                     input logic [4:0] ew, input logic er);
    step();
    bus = '{mem: mem, io: io, rd: 1'b0, addr: a};
    step();
    bus = '0;
    `CHK("window hit", ew, win_hit)
    `CHK("rom hit", er, rom_hit)
  endtask : dec

  // byte k comes from rom address {a[15:2],k} and fills bits 8k+7:8k
  task automatic rom_read(input logic [31:0] a);
    logic [31:0] w;
    int          n;
    for (int k = 0; k < 4; k++)
      w[8*k +: 8] = {a[7:2], 2'(k)} ^ 8'h5A;
    step();
    bus = '{mem: 1'b1, io: 1'b0, rd: 1'b1, addr: a};
    step();
    bus = '0;
    `CHK("rom hit", 1'b1, rom_hit)
    n = 0;
    while (rom_valid !== 1'b1 && n < 100)
    begin
      step();
      n++;
    end
    `CHK("rom valid", 1'b1, rom_valid)
    `CHK("rom word", w, rom_data)
  endtask : rom_read

  // ***********************************************************
  // clock, watchdog and test sequence
  // ***********************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    stop_test();
  end

  initial
  begin
    {resetn_i, slow} = 2'b00;
    {mem_en, io_en} = 2'b11;
    cfg = '0;
    boot = '0;
    bus = '0;
    repeat (8) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    cfg_rd(8'h10, 32'h00000001);
    cfg_rd(8'h30, 32'h00000000);
    for (int w = 1; w < 5; w++)
    begin
      cfg_wr(8'(8'h10 + 4 * w), 32'hFFFFFFFF, 4'hF);
      cfg_rd(8'(8'h10 + 4 * w), 32'h00000000);
    end
    `CHK("bus width", 8'h00, win_width)
    boot_ld(3'h5, 32'hFFFFFFF1);
    cfg_wr(8'h24, 32'hFFFFFFFF, 4'hF);
    cfg_rd(8'h24, 32'h00000000);
    cfg_rd(8'h08, 32'h00000000);
    cfg_wr(8'h10, 32'hFFFFFFFF, 4'hF);
    cfg_rd(8'h10, 32'hFFFFFFC1);
    cfg_wr(8'h10, 32'h00000000, 4'hF);
    cfg_wr(8'h10, 32'hFFFFFFFF, 4'h1);
    cfg_rd(8'h10, 32'h000000C1);
    // boot image then all-ones sizing on each entry of the table
    for (int i = 0; i < 11; i++)
    begin
      boot_ld(t_sel[i], t_img[i]);
      cfg_wr(t_sel[i] == 3'h6 ? 8'h30 : 8'(8'h10 + 4 * t_sel[i]), 32'hFFFFFFFF, 4'hF);
      cfg_rd(t_sel[i] == 3'h6 ? 8'h30 : 8'(8'h10 + 4 * t_sel[i]), t_exp[i]);
    end
    `CHK("bus width", 8'h0F, win_width)
    // window zero back to i/o, then decode checks
    boot_ld(3'h0, 32'hFFFFFFC1);
    cfg_wr(8'h10, 32'h00001000, 4'hF);
    cfg_rd(8'h10, 32'h00001001);
    dec(1'b1, 1'b0, 32'h00001010, 5'h01, 1'b0);
    dec(1'b0, 1'b1, 32'h00001010, 5'h00, 1'b0);
    dec(1'b1, 1'b0, 32'h00002010, 5'h00, 1'b0);
    io_en = 1'b0;
    dec(1'b1, 1'b0, 32'h00001010, 5'h00, 1'b0);
    io_en = 1'b1;
    boot_ld(3'h2, 32'hFFFFFFF2);
    cfg_wr(8'h18, 32'h10000000, 4'hF);
    cfg_rd(8'h18, 32'h10000002);
    dec(1'b0, 1'b1, 32'h10000004, 5'h00, 1'b0);
    cfg_wr(8'h18, 32'h00010000, 4'hF);
    dec(1'b0, 1'b1, 32'h00010004, 5'h04, 1'b0);
    // rom window: decode enable, memory enable, then word fetches
    cfg_wr(8'h30, 32'h00012000, 4'hF);
    cfg_rd(8'h30, 32'h00012000);
    dec(1'b0, 1'b1, 32'h00012004, 5'h00, 1'b0);
    cfg_wr(8'h30, 32'h000127FF, 4'hF);
    cfg_rd(8'h30, 32'h00012001);
    dec(1'b0, 1'b1, 32'h00012004, 5'h00, 1'b1);
    mem_en = 1'b0;
    dec(1'b0, 1'b1, 32'h00012004, 5'h00, 1'b0);
    mem_en = 1'b1;
    rom_read(32'h00012004);
    slow = 1'b1;
    rom_read(32'h0001200C);
    stop_test();
  end
endmodule : test_pawc_window_cfg

bind pawc_window_cfg pawc_window_cfg_chk u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .cfg_i(cfg_i), .cfg_ack_o(cfg_ack_o),
  .cfg_rdata_o(cfg_rdata_o), .mem_space_en_i(mem_space_en_i), .bus_i(bus_i),
  .rom_hit_o(rom_hit_o), .ext_rd_o(ext_rd_o), .ext_addr_o(ext_addr_o),
  .ext_ack_i(ext_ack_i), .rom_valid_o(rom_valid_o));
